// ---- src/gpcde_ports.sv ----
// Ports C, D and E with direction registers, parallel slave mode and a Wishbone slave
// Function
// - Port C direction one floats the pin
// - Port C direction zero drives latch
// - Enabled peripheral overrides port C direction
// - Per-pin select picks latch or peripheral
// - Peripheral enable acts only when selected
// - Reset: directions all ones, latches kept unless power-on
// - Port D pins individually set by direction
// - Mode bit turns port D into slave port
// - Buffers Schmitt in I/O, TTL in slave mode
// - Port E pins individually input or output
// - Slave mode routes port E to strobes
// - Analog port E pins read as zero
// - Port E direction drives pins even analog
// - Power-on makes port E pins analog
// - Status register: flags, mode, direction bits
// - Port E direction one input, zero output
`timescale 1ns/100ps
module gpcde_ports #(
    parameter int unsigned ADR_W = 12
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic POWER_ON_RESET,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Port C pins and peripheral override
    input wire logic [7:0] PC_IN,
    output logic [7:0] PC_OUT,
    output logic [7:0] PC_OE,
    input wire logic [7:0] PERIPH_SEL,
    input wire logic [7:0] PERIPH_OUT,
    input wire logic [7:0] PERIPH_OE,
    input wire logic [7:0] PERIPH_FORCE_EN,
    input wire logic [7:0] PERIPH_FORCE_DIR,
    // Port D pins
    input wire logic [7:0] PD_IN,
    output logic [7:0] PD_OUT,
    output logic [7:0] PD_OE,
    // Port E pins
    input wire logic [2:0] PE_IN,
    output logic [2:0] PE_OUT,
    output logic [2:0] PE_OE,
    // Buffer type and analog selection
    output logic PD_PE_TTL_SEL,
    output logic [2:0] PE_ANALOG_SEL
);
    typedef struct packed {
        logic [7:0] lat_c;
        logic [7:0] lat_d;
        logic [2:0] lat_e;
        logic [7:0] dir_c;
        logic [7:0] dir_d;
        logic [2:0] dir_e;
        logic [2:0] analog;
        logic mode;
        logic input_full_flag;
        logic output_full_flag;
        logic input_overflow_flag;
        logic [7:0] psp_in;
        gpcde_pkg::gpcde_psp_type parallel_slave_port;
        logic ack;
        logic [7:0] rdat;
        logic [7:0] c_out;
        logic [7:0] c_oe;
        logic [7:0] d_out;
        logic [7:0] d_oe;
        logic [2:0] e_out;
        logic [2:0] e_oe;
        logic ttl;
    } gpcde_state_type;

    gpcde_state_type s_q;
    gpcde_state_type s_d;
    logic [18:0] pins_s;
    logic [7:0] pc_s;
    logic [7:0] pd_s;
    logic [2:0] pe_s;
    logic req;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic rd_n;
    logic wr_n;
    logic cs_n;

    // Register index from a byte address
    function automatic logic [7:0] reg_index(input logic [ADR_W-1:0] adr);
        reg_index = adr[9:2];
    endfunction : reg_index

    // Status and direction register as software sees it
    function automatic logic [7:0] status_word(input gpcde_state_type st);
        status_word = {st.input_full_flag, st.output_full_flag, st.input_overflow_flag, st.mode, 1'b0, st.dir_e};
    endfunction : status_word

    gpcde_sync #(
        .W(19)
    ) u_sync (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .d({PE_IN, PD_IN, PC_IN}),
        .q(pins_s)
    );

    assign pc_s = pins_s[7:0];
    assign pd_s = pins_s[15:8];
    assign pe_s = pins_s[18:16];
    assign rd_n = pe_s[0];
    assign wr_n = pe_s[1];
    assign cs_n = pe_s[2];
    assign req = WB_CYC_I && WB_STB_I && !s_q.ack;
    assign wr = req && WB_WE_I && WB_SEL_I[0];
    assign rd = req && !WB_WE_I;
    assign idx = reg_index(WB_ADR_I);
    assign wdat = WB_DAT_I[7:0];

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        // Register writes
        if (wr) begin
            if (idx == gpcde_pkg::IDX_PORT_C_DATA) begin
                s_d.lat_c = wdat;
            end else if (idx == gpcde_pkg::IDX_PORT_D_DATA) begin
                s_d.lat_d = wdat;
                if (s_q.mode) begin
                    s_d.output_full_flag = 1'b1;
                end
            end else if (idx == gpcde_pkg::IDX_PORT_E_DATA) begin
                s_d.lat_e = wdat[2:0];
            end else if (idx == gpcde_pkg::IDX_PORT_C_DIRECTION) begin
                s_d.dir_c = wdat;
            end else if (idx == gpcde_pkg::IDX_PORT_D_DIRECTION) begin
                s_d.dir_d = wdat;
            end else if (idx == gpcde_pkg::IDX_PORT_E_DIR_STATUS) begin
                s_d.input_overflow_flag = wdat[gpcde_pkg::POS_INPUT_OVERFLOW];
                s_d.mode = wdat[gpcde_pkg::POS_MODE_SELECT];
                s_d.dir_e = wdat[2:0];
            end else if (idx == gpcde_pkg::IDX_ANALOG_PIN_CONFIG) begin
                s_d.analog = wdat[2:0];
            end
        end
        // Register reads; unmapped indexes answer zero
        if (rd) begin
            if (idx == gpcde_pkg::IDX_PORT_C_DATA) begin
                s_d.rdat = pc_s;
            end else if (idx == gpcde_pkg::IDX_PORT_D_DATA) begin
                if (s_q.mode) begin
                    s_d.rdat = s_q.psp_in;
                    s_d.input_full_flag = 1'b0;
                end else begin
                    s_d.rdat = pd_s;
                end
            end else if (idx == gpcde_pkg::IDX_PORT_E_DATA) begin
                s_d.rdat = {5'h00, pe_s & ~s_q.analog};
            end else if (idx == gpcde_pkg::IDX_PORT_C_DIRECTION) begin
                s_d.rdat = s_q.dir_c;
            end else if (idx == gpcde_pkg::IDX_PORT_D_DIRECTION) begin
                s_d.rdat = s_q.dir_d;
            end else if (idx == gpcde_pkg::IDX_PORT_E_DIR_STATUS) begin
                s_d.rdat = status_word(s_q);
            end else if (idx == gpcde_pkg::IDX_ANALOG_PIN_CONFIG) begin
                s_d.rdat = {5'h00, s_q.analog};
            end else begin
                s_d.rdat = 8'h00;
            end
        end
        // Slave port strobes; hardware sets win over software clears
        case (s_q.parallel_slave_port)
            gpcde_pkg::PSP_IDLE: begin
                if (s_q.mode && !cs_n && !wr_n) begin
                    s_d.parallel_slave_port = gpcde_pkg::PSP_WRITE;
                end else if (s_q.mode && !cs_n && !rd_n) begin
                    s_d.parallel_slave_port = gpcde_pkg::PSP_READ;
                    s_d.output_full_flag = 1'b0;
                end
            end
            gpcde_pkg::PSP_WRITE: begin
                s_d.psp_in = pd_s;
                if (!s_q.mode) begin
                    s_d.parallel_slave_port = gpcde_pkg::PSP_IDLE;
                end else if (cs_n || wr_n) begin
                    s_d.parallel_slave_port = gpcde_pkg::PSP_IDLE;
                    s_d.psp_in = s_q.psp_in;
                    s_d.input_full_flag = 1'b1;
                    if (s_q.input_full_flag) begin
                        s_d.input_overflow_flag = 1'b1;
                    end
                end
            end
            gpcde_pkg::PSP_READ: begin
                if (!s_q.mode || cs_n || rd_n) begin
                    s_d.parallel_slave_port = gpcde_pkg::PSP_IDLE;
                end
            end
            default: begin
                s_d.parallel_slave_port = gpcde_pkg::PSP_IDLE;
            end
        endcase
        if (!s_q.mode) begin
            s_d.input_full_flag = 1'b0;
            s_d.output_full_flag = 1'b0;
        end
        // Port C output path with peripheral override
        s_d.c_out = (PERIPH_SEL & PERIPH_OUT) | (~PERIPH_SEL & s_q.lat_c);
        s_d.c_oe = (PERIPH_SEL & PERIPH_OE)
            | (~PERIPH_SEL & PERIPH_FORCE_EN & ~PERIPH_FORCE_DIR)
            | (~PERIPH_SEL & ~PERIPH_FORCE_EN & ~s_q.dir_c);
        // Port D: direction register in I/O mode, read strobe in slave mode
        s_d.d_out = s_q.lat_d;
        if (s_q.mode) begin
            s_d.d_oe = (s_q.parallel_slave_port == gpcde_pkg::PSP_READ) ? 8'hff : 8'h00;
        end else begin
            s_d.d_oe = ~s_q.dir_d;
        end
        // Port E: direction bits rule the drivers, analog or not
        s_d.e_out = s_q.lat_e;
        s_d.e_oe = ~s_q.dir_e;
        s_d.ttl = s_q.mode;
        if (!RESET_N) begin
            s_d.dir_c = gpcde_pkg::RST_PORT_C_DIRECTION;
            s_d.dir_d = gpcde_pkg::RST_PORT_D_DIRECTION;
            s_d.dir_e = gpcde_pkg::RST_PORT_E_DIRECTION;
            s_d.mode = 1'b0;
            s_d.input_full_flag = 1'b0;
            s_d.output_full_flag = 1'b0;
            s_d.input_overflow_flag = 1'b0;
            s_d.analog = gpcde_pkg::RST_ANALOG_PIN_CONFIG;
            s_d.parallel_slave_port = gpcde_pkg::PSP_IDLE;
            s_d.ack = 1'b0;
            s_d.rdat = 8'h00;
            s_d.c_oe = 8'h00;
            s_d.d_oe = 8'h00;
            s_d.e_oe = 3'h0;
            s_d.ttl = 1'b0;
            if (POWER_ON_RESET) begin
                s_d.lat_c = gpcde_pkg::RST_DATA_LATCH;
                s_d.lat_d = gpcde_pkg::RST_DATA_LATCH;
                s_d.lat_e = gpcde_pkg::RST_DATA_LATCH[2:0];
                s_d.psp_in = gpcde_pkg::RST_DATA_LATCH;
                s_d.c_out = gpcde_pkg::RST_DATA_LATCH;
                s_d.d_out = gpcde_pkg::RST_DATA_LATCH;
                s_d.e_out = gpcde_pkg::RST_DATA_LATCH[2:0];
                s_d.analog = gpcde_pkg::RST_ANALOG_PIN_CONFIG;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        s_q <= s_d;
    end

    assign WB_DAT_O = {24'h000000, s_q.rdat};
    assign WB_ACK_O = s_q.ack;
    assign PC_OUT = s_q.c_out;
    assign PC_OE = s_q.c_oe;
    assign PD_OUT = s_q.d_out;
    assign PD_OE = s_q.d_oe;
    assign PE_OUT = s_q.e_out;
    assign PE_OE = s_q.e_oe;
    assign PD_PE_TTL_SEL = s_q.ttl;
    assign PE_ANALOG_SEL = s_q.analog;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence seq_psp_write_start;
        s_q.parallel_slave_port == gpcde_pkg::PSP_IDLE && s_q.mode && !cs_n && !wr_n;
    endsequence
    sequence seq_psp_write_end;
        s_q.parallel_slave_port == gpcde_pkg::PSP_WRITE && s_q.mode && (cs_n || wr_n);
    endsequence
    sequence seq_psp_read_start;
        s_q.parallel_slave_port == gpcde_pkg::PSP_IDLE && s_q.mode && !cs_n && wr_n && !rd_n;
    endsequence
    sequence seq_e_data_read;
        rd && idx == gpcde_pkg::IDX_PORT_E_DATA;
    endsequence

    AST_C_INPUT_FLOATS: assert property (
        (s_q.dir_c == 8'hff && PERIPH_SEL == 8'h00 && PERIPH_FORCE_EN == 8'h00)
        |=> PC_OE == 8'h00)
        else $error("port C driver on while all directions are input");
    AST_C_DRIVES_LATCH: assert property (
        (PERIPH_SEL == 8'h00 && PERIPH_FORCE_EN == 8'h00)
        |=> PC_OUT == $past(s_q.lat_c) && PC_OE == ~$past(s_q.dir_c))
        else $error("port C output does not follow latch and direction");
    AST_C_FORCE_OVERRIDE: assert property (
        1'b1 |=> ((PC_OE ^ ~$past(PERIPH_FORCE_DIR)) & ~$past(PERIPH_SEL)
            & $past(PERIPH_FORCE_EN)) == 8'h00)
        else $error("peripheral force did not override port C direction");
    AST_C_PERIPH_PATH: assert property (
        1'b1 |=> ((PC_OUT ^ $past(PERIPH_OUT)) & $past(PERIPH_SEL)) == 8'h00
            && ((PC_OE ^ $past(PERIPH_OE)) & $past(PERIPH_SEL)) == 8'h00)
        else $error("selected peripheral does not own port C pins");
    AST_C_OE_NEEDS_SEL: assert property (
        1'b1 |=> ((PC_OE ^ ~$past(s_q.dir_c)) & ~$past(PERIPH_SEL)
            & ~$past(PERIPH_FORCE_EN)) == 8'h00)
        else $error("unselected peripheral enable reached a port C pin");
    AST_RESET_DIRECTIONS: assert property (
        disable iff (1'b0)
        !RESET_N |=> s_q.dir_c == 8'hff && s_q.dir_d == 8'hff
            && status_word(s_q) == 8'h07)
        else $error("directions or status wrong after reset");
    AST_RESET_KEEPS_LATCH: assert property (
        disable iff (1'b0)
        (!RESET_N && !POWER_ON_RESET) |=> s_q.lat_c == $past(s_q.lat_c)
            && s_q.lat_d == $past(s_q.lat_d))
        else $error("data latch changed by a non power-on reset");
    AST_D_IO_DIRECTION: assert property (
        !s_q.mode |=> PD_OE == ~$past(s_q.dir_d))
        else $error("port D driver does not follow its direction");
    AST_D_SLAVE_DRIVE: assert property (
        (s_q.mode && s_q.parallel_slave_port == gpcde_pkg::PSP_READ)
        |=> PD_OE == 8'hff && PD_OUT == $past(s_q.lat_d))
        else $error("slave read does not drive the port D latch");
    AST_TTL_FOLLOWS_MODE: assert property (
        $changed(s_q.mode) |=> PD_PE_TTL_SEL == $past(s_q.mode))
        else $error("buffer type does not follow slave mode");
    AST_PSP_WRITE_START: assert property (
        seq_psp_write_start |=> s_q.parallel_slave_port == gpcde_pkg::PSP_WRITE)
        else $error("slave write strobes did not start a write");
    AST_PSP_READ_START: assert property (
        seq_psp_read_start |=> s_q.parallel_slave_port == gpcde_pkg::PSP_READ && !s_q.output_full_flag)
        else $error("slave read strobes did not start a read");
    AST_PSP_WRITE_FLAGS: assert property (
        seq_psp_write_end |=> s_q.input_full_flag && s_q.parallel_slave_port == gpcde_pkg::PSP_IDLE)
        else $error("completed slave write did not set input full");
    AST_PSP_OVERFLOW: assert property (
        (seq_psp_write_end and s_q.input_full_flag) |=> s_q.input_overflow_flag)
        else $error("second slave write did not flag overflow");
    AST_E_ANALOG_ZERO: assert property (
        seq_e_data_read |=> WB_ACK_O && (WB_DAT_O[2:0] & $past(s_q.analog)) == 3'h0)
        else $error("analog port E pin read as nonzero");
    AST_E_DIRECTION: assert property (
        1'b1 |=> PE_OE == ~$past(s_q.dir_e))
        else $error("port E driver does not follow its direction");
    AST_POR_ANALOG: assert property (
        disable iff (1'b0)
        (!RESET_N && POWER_ON_RESET) |=> PE_ANALOG_SEL == 3'h7)
        else $error("port E not analog after power-on reset");
    AST_C_WRITE_LATCH: assert property (
        (wr && idx == gpcde_pkg::IDX_PORT_C_DATA) |=> s_q.lat_c == $past(wdat) && WB_ACK_O)
        else $error("port C data write lost");
endmodule : gpcde_ports

// ---- src/gpcde_pkg.sv ----
// Constants and types shared by the port C/D/E block
package gpcde_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_PORT_C_DATA = 8'h07;
    localparam logic [7:0] IDX_PORT_D_DATA = 8'h08;
    localparam logic [7:0] IDX_PORT_E_DATA = 8'h09;
    localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
    localparam logic [7:0] IDX_PORT_D_DIRECTION = 8'h88;
    localparam logic [7:0] IDX_PORT_E_DIR_STATUS = 8'h89;
    localparam logic [7:0] IDX_ANALOG_PIN_CONFIG = 8'h9f;
    // Field positions in the port E direction and slave status register
    localparam int unsigned POS_INPUT_FULL = 7;
    localparam int unsigned POS_OUTPUT_FULL = 6;
    localparam int unsigned POS_INPUT_OVERFLOW = 5;
    localparam int unsigned POS_MODE_SELECT = 4;
    // Values after reset
    localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hff;
    localparam logic [7:0] RST_PORT_D_DIRECTION = 8'hff;
    localparam logic [2:0] RST_PORT_E_DIRECTION = 3'h7;
    localparam logic [2:0] RST_ANALOG_PIN_CONFIG = 3'h7;
    localparam logic [7:0] RST_DATA_LATCH = 8'h00;
    // Synchroniser depth on pin inputs, in cycles
    localparam int unsigned SYNC_CYCLES = 2;

    typedef enum logic [1:0] {
        PSP_IDLE = 2'b00,
        PSP_WRITE = 2'b01,
        PSP_READ = 2'b10
    } gpcde_psp_type;
endpackage : gpcde_pkg

// ---- src/gpcde_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module gpcde_sync #(
    parameter int unsigned W = 19
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous levels and their synchronised copies
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } gpcde_sync_state_type;

    gpcde_sync_state_type s_q;
    gpcde_sync_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = d;
        s_d.stable = s_q.meta;
        if (!rst_n) begin
            s_d.meta = '0;
            s_d.stable = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign q = s_q.stable;
endmodule : gpcde_sync

// ---- bench/gpcde_pin_model.sv ----
// Board-side model of the port pins: each pin resolved from block drive and board drive
`timescale 1ns/100ps
module gpcde_pin_model (
    // Block drive
    input wire logic [7:0] c_out,
    input wire logic [7:0] c_oe,
    input wire logic [7:0] d_out,
    input wire logic [7:0] d_oe,
    input wire logic [2:0] e_out,
    input wire logic [2:0] e_oe,
    // Board drive where the block floats a pin
    input wire logic [7:0] c_ext,
    input wire logic [7:0] d_ext,
    input wire logic [2:0] e_ext,
    // Pin levels
    output logic [7:0] c_pin,
    output logic [7:0] d_pin,
    output logic [2:0] e_pin
);
    // A floated pin shows the board level, a driven pin the block level
    assign c_pin = (c_oe & c_out) | (~c_oe & c_ext);
    assign d_pin = (d_oe & d_out) | (~d_oe & d_ext);
    assign e_pin = (e_oe & e_out) | (~e_oe & e_ext);
endmodule : gpcde_pin_model

// ---- bench/test_gpcde_ports.sv ----
// Self-checking bench for the port C/D/E block
`timescale 1ns/100ps
module test_gpcde_ports;
    logic CORE_CLK, RESET_N, POWER_ON_RESET, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic PD_PE_TTL_SEL;
    logic [11:0] WB_ADR_I;
    logic [3:0] WB_SEL_I;
    logic [31:0] WB_DAT_I, WB_DAT_O, rd;
    logic [7:0] PC_IN, PC_OUT, PC_OE, PD_IN, PD_OUT, PD_OE, ext_c, ext_d;
    logic [7:0] PERIPH_SEL, PERIPH_OUT, PERIPH_OE, PERIPH_FORCE_EN, PERIPH_FORCE_DIR;
    logic [2:0] PE_IN, PE_OUT, PE_OE, PE_ANALOG_SEL, ext_e;
    int n_fail = 0;
    int checked = 0;

    gpcde_ports dut (
        .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .POWER_ON_RESET(POWER_ON_RESET),
        .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
        .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .PC_IN(PC_IN), .PC_OUT(PC_OUT), .PC_OE(PC_OE), .PERIPH_SEL(PERIPH_SEL),
        .PERIPH_OUT(PERIPH_OUT), .PERIPH_OE(PERIPH_OE), .PERIPH_FORCE_EN(PERIPH_FORCE_EN),
        .PERIPH_FORCE_DIR(PERIPH_FORCE_DIR), .PD_IN(PD_IN), .PD_OUT(PD_OUT), .PD_OE(PD_OE),
        .PE_IN(PE_IN), .PE_OUT(PE_OUT), .PE_OE(PE_OE), .PD_PE_TTL_SEL(PD_PE_TTL_SEL),
        .PE_ANALOG_SEL(PE_ANALOG_SEL)
    );

    gpcde_pin_model pins (
        .c_out(PC_OUT), .c_oe(PC_OE), .d_out(PD_OUT), .d_oe(PD_OE),
        .e_out(PE_OUT), .e_oe(PE_OE), .c_ext(ext_c), .d_ext(ext_d), .e_ext(ext_e),
        .c_pin(PC_IN), .d_pin(PD_IN), .e_pin(PE_IN)
    );

    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One classic Wishbone cycle; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge CORE_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_SEL_I <= 4'h1;
        WB_ADR_I <= {2'h0, idx, 2'h0};
        WB_DAT_I <= {24'h0, wd};
        // Ack and data are taken at the rising edge; only the watchdog ends a hang
        do begin
            @(posedge CORE_CLK);
        end while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
    endtask : wb

    task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check(name, rd, {24'h0, exp});
    endtask : rdchk

    task automatic settle();
        repeat (5) @(negedge CORE_CLK);
    endtask : settle

    // External processor cycle on the slave port; control bits are cs, wr, rd
    task automatic host_cycle(input logic [2:0] ctl, input logic [7:0] d);
        @(posedge CORE_CLK);
        ext_d <= d;
        ext_e <= ctl;
        repeat (5) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        if (ctl == 3'b010) begin
            check("slave read enable", PD_OE, 8'hff);
            check("slave read data", PD_OUT, {24'h0, d});
        end
        @(posedge CORE_CLK);
        ext_e <= 3'b111;
        repeat (6) @(posedge CORE_CLK);
    endtask : host_cycle

    initial begin
        repeat (5000) @(posedge CORE_CLK);
        n_fail++;
        $display("ERROR watchdog expected finish seen hang");
        report_and_stop();
    end

    initial begin
        RESET_N = 1'b0;
        POWER_ON_RESET = 1'b1;
        WB_CYC_I = 1'b0;
        WB_STB_I = 1'b0;
        WB_WE_I = 1'b0;
        WB_ADR_I = 12'h000;
        WB_SEL_I = 4'h1;
        WB_DAT_I = 32'h0;
        PERIPH_SEL = 8'h00;
        PERIPH_OUT = 8'h00;
        PERIPH_OE = 8'h00;
        PERIPH_FORCE_EN = 8'h00;
        PERIPH_FORCE_DIR = 8'h00;
        ext_c = 8'h3c;
        ext_d = 8'h00;
        ext_e = 3'b111;
        repeat (10) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        POWER_ON_RESET <= 1'b0;
        @(negedge CORE_CLK);
        check("c enable", PC_OE, 8'h00);
        check("d enable", PD_OE, 8'h00);
        check("e enable", PE_OE, 3'h0);
        check("analog sel", PE_ANALOG_SEL, 3'h7);
        check("ttl sel", PD_PE_TTL_SEL, 1'b0);
        rdchk("c dir", gpcde_pkg::IDX_PORT_C_DIRECTION, 8'hff);
        rdchk("d dir", gpcde_pkg::IDX_PORT_D_DIRECTION, 8'hff);
        rdchk("e status", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'h07);
        rdchk("unmapped", 8'h50, 8'h00);
        $display("test reset values done");

        wb(1'b1, gpcde_pkg::IDX_PORT_C_DATA, 8'ha5);
        wb(1'b1, gpcde_pkg::IDX_PORT_C_DIRECTION, 8'h0f);
        settle();
        check("c enable", PC_OE, 8'hf0);
        check("c out", PC_OUT & 8'hf0, 8'ha0);
        rdchk("c pins", gpcde_pkg::IDX_PORT_C_DATA, 8'hac);
        @(posedge CORE_CLK);
        PERIPH_SEL <= 8'h01;
        PERIPH_OE <= 8'h05;
        PERIPH_FORCE_EN <= 8'h82;
        PERIPH_FORCE_DIR <= 8'h80;
        settle();
        check("c override enable", PC_OE, 8'h73);
        check("c override out", PC_OUT & 8'h73, 8'h20);
        $display("test port c done");

        wb(1'b1, gpcde_pkg::IDX_PORT_D_DATA, 8'h5a);
        wb(1'b1, gpcde_pkg::IDX_PORT_D_DIRECTION, 8'h33);
        settle();
        check("d enable", PD_OE, 8'hcc);
        rdchk("d pins", gpcde_pkg::IDX_PORT_D_DATA, 8'h48);
        wb(1'b1, gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'hca);
        rdchk("e status", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'h02);
        wb(1'b1, gpcde_pkg::IDX_PORT_E_DATA, 8'h05);
        settle();
        check("e enable", PE_OE, 3'b101);
        check("e out", PE_OUT & 3'b101, 3'b101);
        @(posedge CORE_CLK);
        ext_e <= 3'b010;
        rdchk("e analog read", gpcde_pkg::IDX_PORT_E_DATA, 8'h00);
        wb(1'b1, gpcde_pkg::IDX_ANALOG_PIN_CONFIG, 8'h00);
        settle();
        rdchk("e digital read", gpcde_pkg::IDX_PORT_E_DATA, 8'h07);
        $display("test ports d e done");

        @(posedge CORE_CLK);
        ext_e <= 3'b111;
        wb(1'b1, gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'h17);
        settle();
        check("ttl sel", PD_PE_TTL_SEL, 1'b1);
        check("d enable in mode", PD_OE, 8'h00);
        host_cycle(3'b001, 8'h96);
        rdchk("input full", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'h97);
        rdchk("captured", gpcde_pkg::IDX_PORT_D_DATA, 8'h96);
        rdchk("full cleared", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'h17);
        host_cycle(3'b001, 8'h11);
        host_cycle(3'b001, 8'h22);
        rdchk("overflow", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'hb7);
        wb(1'b1, gpcde_pkg::IDX_PORT_D_DATA, 8'h3c);
        rdchk("output full", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'hf7);
        host_cycle(3'b010, 8'h3c);
        rdchk("output taken", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'hb7);
        $display("test slave port done");

        @(posedge CORE_CLK);
        RESET_N <= 1'b0;
        PERIPH_SEL <= 8'h00;
        PERIPH_FORCE_EN <= 8'h00;
        repeat (10) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        rdchk("c dir warm", gpcde_pkg::IDX_PORT_C_DIRECTION, 8'hff);
        rdchk("e status warm", gpcde_pkg::IDX_PORT_E_DIR_STATUS, 8'h07);
        wb(1'b1, gpcde_pkg::IDX_PORT_C_DIRECTION, 8'h00);
        settle();
        check("c latch kept", PC_OUT, 8'ha5);
        check("ttl sel warm", PD_PE_TTL_SEL, 1'b0);
        $display("test warm reset done");
        report_and_stop();
    end
endmodule : test_gpcde_ports
